// ===== rtl/eia_top.sv
/*
  External edge select, pin 0 noise filter, status word and interrupt
  acknowledge decision. Assumes a CPU sequencer that pulses INSTR_DONE at
  each instruction end, with the instruction-kind pulses in that cycle,
  and that waits two cycles after INSTR_DONE for an acknowledge.
*/
`timescale 1ns/1ns
module eia_top (
  input  wire logic                         CLK,
  input  wire logic                         RESET,
  input  wire logic                         CE,
  input  wire logic [eia_pkg::N_PIN-1:0]    EXT_IRQ_PIN,
  input  wire logic [eia_pkg::N_OTHER-1:0]  OTHER_REQ,
  input  wire logic                         NMI_REQ,
  input  wire logic [eia_pkg::N_SRC-1:0]    MASK_FLAGS,
  input  wire logic [eia_pkg::N_SRC-1:0]    PRIO_FLAGS,
  input  wire logic                         OSC_MODE_BIT,
  input  wire logic                         FXX_HALF,
  input  wire logic [2:0]                   CPU_DIV_N,
  input  wire logic                         HALT_MODE,
  input  wire logic                         INSTR_DONE,
  input  wire logic                         HOLD_INSTR,
  input  wire logic                         EI_INSTR,
  input  wire logic                         DI_INSTR,
  input  wire logic                         BRK_INSTR,
  input  wire logic                         INTERRUPT_RETURN_INSTR_INSTR,
  input  wire logic                         BREAK_RETURN_INSTR_INSTR,
  input  wire logic                         PUSH_PSW_INSTR,
  input  wire logic                         POP_PSW_INSTR,
  input  wire logic [7:0]                   POP_DATA,
  input  wire logic [15:0]                  REG_ADDR,
  input  wire logic [7:0]                   REG_WDATA,
  input  wire logic                         REG_WE,
  input  wire logic                         REG_RE,
  output logic      [7:0]                   REG_RDATA,
  output logic      [7:0]                   PROCESSOR_STATUS_WORD,
  output logic      [eia_pkg::N_SRC-1:0]    REQ_FLAGS,
  output logic                              NMI_PENDING,
  output logic                              NMI_IN_SERVICE,
  output logic                              ACK,
  output logic                              ACK_NMI,
  output logic      [eia_pkg::SRC_W-1:0]    ACK_SRC,
  output logic                              PSW_PUSH,
  output logic      [7:0]                   PSW_PUSH_DATA
);

  logic [1:0]                  scs_q;
  logic [5:0]                  edge_lo_q;
  logic [5:0]                  edge_up_q;
  logic [7:0]                  psw_q;
  logic [7:0]                  psw_d;
  logic [eia_pkg::PRE_W-1:0]   pre_q;
  logic                        smp_q;
  logic                        flt_q;
  logic [eia_pkg::N_PIN-1:0]   prev_q;
  logic [eia_pkg::N_SRC-1:0]   req_q;
  logic                        nmi_pend_q;
  logic                        nmi_svc_q;
  eia_pkg::eia_state_t         st_q;
  logic [eia_pkg::SRC_W-1:0]   held_id_q;
  logic [7:0]                  rdata_q;
  logic                        ack_q;
  logic                        ack_nmi_q;
  logic [eia_pkg::SRC_W-1:0]   ack_src_q;
  logic                        push_q;
  logic [7:0]                  push_data_q;

  // Register decode
  wire wr_scs  = REG_WE && (REG_ADDR == eia_pkg::ADR_SCS);
  wire wr_up   = REG_WE && (REG_ADDR == eia_pkg::ADR_EDGE_UP);
  wire wr_lo   = REG_WE && (REG_ADDR == eia_pkg::ADR_EDGE_LO);
  wire wr_psw  = REG_WE && (REG_ADDR == eia_pkg::ADR_PSW);
  wire [7:0] rd_mux =
    (REG_ADDR == eia_pkg::ADR_SCS)     ? {6'h00, scs_q} :
    (REG_ADDR == eia_pkg::ADR_EDGE_UP) ? {2'h0, edge_up_q} :
    (REG_ADDR == eia_pkg::ADR_EDGE_LO) ? {edge_lo_q, 2'h0} :
    (REG_ADDR == eia_pkg::ADR_PSW)     ? psw_q : eia_pkg::RD_NONE;

  wire psw_ie  = psw_q[eia_pkg::PSW_IE];
  wire psw_isp = psw_q[eia_pkg::PSW_ISP];

  // Sampling clock for pin 0, derived from a free-running fx prescaler
  wire [3:0] cpu_exp = {1'b0, CPU_DIV_N} + {3'h0, FXX_HALF};
  wire [3:0] per_exp =
    OSC_MODE_BIT ? ((scs_q == eia_pkg::SCS_DIVA) ? eia_pkg::EXP_M1_A :
                    (scs_q == eia_pkg::SCS_DIVB) ? eia_pkg::EXP_M1_B : eia_pkg::EXP_M1_C)
                 : ((scs_q == eia_pkg::SCS_DIVA) ? eia_pkg::EXP_M0_A :
                    (scs_q == eia_pkg::SCS_DIVB) ? eia_pkg::EXP_M0_B : eia_pkg::EXP_M0_C);
  wire       use_cpu = (scs_q == eia_pkg::SCS_CPU);
  wire [3:0] smp_exp = use_cpu ? cpu_exp : per_exp;
  wire [eia_pkg::PRE_W-1:0] smp_mask =
    eia_pkg::PRE_W'(({{eia_pkg::PRE_W{1'b0}}, 1'b1} << smp_exp) - 1'b1);
  // CPU clock stops in halt, so the filter freezes too when it samples on the CPU clock
  wire tick = ((pre_q & smp_mask) == smp_mask) && !(use_cpu && HALT_MODE);

  // Pin levels seen by the edge detectors; pin 0 through the filter
  wire [eia_pkg::N_PIN-1:0] lvl = {EXT_IRQ_PIN[eia_pkg::N_PIN-1:1], flt_q};
  wire [eia_pkg::N_PIN-1:0] pin_evt;
  wire [eia_pkg::N_SRC-1:0] src_evt = {OTHER_REQ, pin_evt};
  wire [2*eia_pkg::N_PIN-1:0] edge_all = {edge_up_q, edge_lo_q};

  genvar gi;
  generate
    for (gi = 0; gi < eia_pkg::N_PIN; gi++)
    begin : g_pin
      wire [1:0] mode = edge_all[2*gi +: 2];
      wire rise = lvl[gi] && !prev_q[gi];
      wire fall = !lvl[gi] && prev_q[gi];
      assign pin_evt[gi] =
        ((mode == eia_pkg::EDGE_FALL) && fall) ||
        ((mode == eia_pkg::EDGE_RISE) && rise) ||
        ((mode == eia_pkg::EDGE_BOTH) && (rise || fall));
    end
  endgenerate

  // Candidate selection: high group first, lowest index wins inside a group
  function automatic logic [eia_pkg::SRC_W:0] pick_first(
    input logic [eia_pkg::N_SRC-1:0] v
  );
    logic [eia_pkg::SRC_W:0] r;
    r = '0;
    for (int i = eia_pkg::N_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, eia_pkg::SRC_W'(i)};
      end
    end
    return r;
  endfunction

  wire [eia_pkg::N_SRC-1:0] cand    = req_q & ~MASK_FLAGS;
  wire [eia_pkg::N_SRC-1:0] cand_hi = cand & ~PRIO_FLAGS;
  wire [eia_pkg::N_SRC-1:0] cand_lo = psw_isp ? (cand & PRIO_FLAGS) : '0;
  wire [eia_pkg::SRC_W:0]   pk_hi   = pick_first(cand_hi);
  wire [eia_pkg::SRC_W:0]   pk_lo   = pick_first(cand_lo);
  wire                      pk_any  = pk_hi[eia_pkg::SRC_W] || pk_lo[eia_pkg::SRC_W];
  wire [eia_pkg::SRC_W-1:0] pk_id   = pk_hi[eia_pkg::SRC_W] ?
                                      pk_hi[eia_pkg::SRC_W-1:0] : pk_lo[eia_pkg::SRC_W-1:0];
  wire                      pk_low  = !pk_hi[eia_pkg::SRC_W];

  // Instructions that touch the status word, except BRK_INSTR, defer acknowledge by one
  wire held = HOLD_INSTR || EI_INSTR || DI_INSTR || INTERRUPT_RETURN_INSTR_INSTR ||
              BREAK_RETURN_INSTR_INSTR || PUSH_PSW_INSTR || POP_PSW_INSTR;
  wire take_ok = INSTR_DONE && !held && !nmi_svc_q;

  wire held_ok  = cand[held_id_q] && psw_ie && !nmi_svc_q &&
                  (psw_isp || !PRIO_FLAGS[held_id_q]);
  wire iss_nmi  = nmi_pend_q && !nmi_svc_q &&
                  ((st_q == eia_pkg::ST_IDLE && take_ok) || st_q == eia_pkg::ST_LOWWAIT);
  wire iss_hi   = (st_q == eia_pkg::ST_IDLE) && take_ok && !nmi_pend_q &&
                  psw_ie && pk_any && !pk_low;
  wire go_low   = (st_q == eia_pkg::ST_IDLE) && take_ok && !nmi_pend_q &&
                  psw_ie && pk_any && pk_low;
  // Low-priority requests spend one extra cycle in the decision
  wire iss_low  = (st_q == eia_pkg::ST_LOWWAIT) && !nmi_pend_q && held_ok;
  wire iss_msk  = iss_hi || iss_low;
  wire [eia_pkg::SRC_W-1:0] iss_id = iss_low ? held_id_q : pk_id;
  wire iss      = iss_nmi || iss_msk;

  eia_pkg::eia_state_t st_d;
  assign st_d = go_low ? eia_pkg::ST_LOWWAIT : eia_pkg::ST_IDLE;

  // Status word next value
  always_comb
  begin
    psw_d = psw_q;
    // Non-maskable acknowledge clears the in-service priority as well
    if (iss)
    begin
      psw_d[eia_pkg::PSW_IE]  = 1'b0;
      psw_d[eia_pkg::PSW_ISP] = iss_msk && PRIO_FLAGS[iss_id];
    end
    else if (BRK_INSTR)
    begin
      psw_d[eia_pkg::PSW_IE] = 1'b0;
    end
    else if (INTERRUPT_RETURN_INSTR_INSTR || BREAK_RETURN_INSTR_INSTR || POP_PSW_INSTR)
    begin
      psw_d = POP_DATA;
    end
    else if (EI_INSTR || DI_INSTR)
    begin
      psw_d[eia_pkg::PSW_IE] = EI_INSTR;
    end
    else if (wr_psw)
    begin
      psw_d = REG_WDATA;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      scs_q     <= eia_pkg::RST_SCS[1:0];
      edge_lo_q <= eia_pkg::RST_EDGE[7:2];
      edge_up_q <= eia_pkg::RST_EDGE[5:0];
      psw_q     <= eia_pkg::RST_PSW;
    end
    else if (CE)
    begin
      if (wr_scs) scs_q <= REG_WDATA[1:0];
      if (wr_lo) edge_lo_q <= REG_WDATA[7:2];
      if (wr_up) edge_up_q <= REG_WDATA[5:0];
      psw_q <= psw_d;
    end
  end

  // Filter moves only after two equal samples in a row
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pre_q  <= '0;
      smp_q  <= 1'b0;
      flt_q  <= 1'b0;
      prev_q <= '0;
    end
    else if (CE)
    begin
      pre_q  <= pre_q + 1'b1;
      prev_q <= lvl;
      if (tick)
      begin
        smp_q <= EXT_IRQ_PIN[0];
        if (EXT_IRQ_PIN[0] == smp_q) flt_q <= smp_q;
      end
    end
  end

  generate
    for (gi = 0; gi < eia_pkg::N_SRC; gi++)
    begin : g_req
      always_ff @(posedge CLK)
      begin
        if (RESET) req_q[gi] <= 1'b0;
        else if (CE && src_evt[gi]) req_q[gi] <= 1'b1;
        else if (CE && iss_msk && iss_id == gi) req_q[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      nmi_pend_q <= 1'b0;
      nmi_svc_q  <= 1'b0;
      st_q       <= eia_pkg::ST_IDLE;
      held_id_q  <= '0;
    end
    else if (CE)
    begin
      // One flag, so repeats during service fold into a single request
      if (NMI_REQ) nmi_pend_q <= 1'b1;
      else if (iss_nmi) nmi_pend_q <= 1'b0;
      if (iss_nmi) nmi_svc_q <= 1'b1;
      else if (INTERRUPT_RETURN_INSTR_INSTR) nmi_svc_q <= 1'b0;
      st_q <= st_d;
      if (go_low) held_id_q <= pk_id;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      rdata_q     <= eia_pkg::RD_NONE;
      ack_q       <= 1'b0;
      ack_nmi_q   <= 1'b0;
      ack_src_q   <= '0;
      push_q      <= 1'b0;
      push_data_q <= '0;
    end
    else if (CE)
    begin
      if (REG_RE) rdata_q <= rd_mux;
      ack_q     <= iss;
      ack_nmi_q <= iss_nmi;
      if (iss_msk) ack_src_q <= iss_id;
      push_q    <= iss || BRK_INSTR || PUSH_PSW_INSTR;
      if (iss || BRK_INSTR || PUSH_PSW_INSTR) push_data_q <= psw_q;
    end
  end

  assign REG_RDATA      = rdata_q;
  assign PROCESSOR_STATUS_WORD            = psw_q;
  assign REQ_FLAGS      = req_q;
  assign NMI_PENDING    = nmi_pend_q;
  assign NMI_IN_SERVICE = nmi_svc_q;
  assign ACK            = ack_q;
  assign ACK_NMI        = ack_nmi_q;
  assign ACK_SRC        = ack_src_q;
  assign PSW_PUSH       = push_q;
  assign PSW_PUSH_DATA  = push_data_q;

  // Checks
  sequence s_nmi_take;
    CE && nmi_pend_q && !nmi_svc_q && take_ok;
  endsequence
  sequence s_ack_out;
    ack_q && ack_nmi_q && push_q && !psw_q[eia_pkg::PSW_IE] && !psw_q[eia_pkg::PSW_ISP];
  endsequence

  property p_bad_edge;
    @(posedge CLK) disable iff (RESET)
      (edge_lo_q[1:0] == eia_pkg::EDGE_BAD) |-> !pin_evt[0];
  endproperty
  a_bad_edge: assert property (p_bad_edge) else $error("forbidden edge mode fired");
  property p_reset_vals;
    @(posedge CLK) disable iff (RESET)
      $fell(RESET) |-> (edge_lo_q == '0 && edge_up_q == '0 && scs_q == '0 &&
                        psw_q == eia_pkg::RST_PSW);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
  property p_up_read;
    @(posedge CLK) disable iff (RESET)
      (CE && REG_RE && REG_ADDR == eia_pkg::ADR_EDGE_UP) |=> (REG_RDATA[7:6] == 2'h0);
  endproperty
  a_up_read: assert property (p_up_read) else $error("upper edge bits 7:6 not zero");
  property p_filter;
    @(posedge CLK) disable iff (RESET)
      $rose(flt_q) |-> ($past(tick) && $past(smp_q) && $past(EXT_IRQ_PIN[0]));
  endproperty
  a_filter: assert property (p_filter) else $error("filter rose without two samples");
  property p_halt_stop;
    @(posedge CLK) disable iff (RESET)
      (use_cpu && HALT_MODE) |-> !tick;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("sampling ran in halt");
  property p_nmi_ack;
    @(posedge CLK) disable iff (RESET)
      s_nmi_take |=> s_ack_out;
  endproperty
  a_nmi_ack: assert property (p_nmi_ack) else $error("nmi not acknowledged");
  property p_ack_push;
    @(posedge CLK) disable iff (RESET)
      $rose(ack_q) |-> (push_q && !psw_q[eia_pkg::PSW_IE] && push_data_q == $past(psw_q));
  endproperty
  a_ack_push: assert property (p_ack_push) else $error("ack without push");
  property p_msk_ie;
    @(posedge CLK) disable iff (RESET)
      iss_msk |-> (psw_ie && !nmi_svc_q && cand[iss_id]);
  endproperty
  a_msk_ie: assert property (p_msk_ie) else $error("maskable taken while disabled");
  property p_isp_block;
    @(posedge CLK) disable iff (RESET)
      (iss_msk && !psw_isp) |-> !PRIO_FLAGS[iss_id];
  endproperty
  a_isp_block: assert property (p_isp_block) else $error("low taken under high service");
  property p_nmi_svc;
    @(posedge CLK) disable iff (RESET)
      nmi_svc_q |-> !iss;
  endproperty
  a_nmi_svc: assert property (p_nmi_svc) else $error("ack during nmi service");
  property p_isp_copy;
    @(posedge CLK) disable iff (RESET)
      (CE && iss_msk) |=> (psw_q[eia_pkg::PSW_ISP] == $past(PRIO_FLAGS[iss_id]));
  endproperty
  a_isp_copy: assert property (p_isp_copy) else $error("priority not copied");
  property p_set_wins;
    @(posedge CLK) disable iff (RESET)
      (CE && src_evt[0]) |=> req_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("request event lost");

endmodule

// ===== rtl/eia_pkg.sv
/*
  Constants for the external edge and interrupt acknowledge block.
  Assumes one 8-bit register port from the CPU core.
*/
package eia_pkg;
  localparam int unsigned N_PIN   = 6;
  localparam int unsigned N_OTHER = 10;
  localparam int unsigned N_SRC   = 16;
  localparam int unsigned SRC_W   = 4;
  localparam int unsigned PRE_W   = 9;

  // Register port addresses
  localparam logic [15:0] ADR_SCS     = 16'hFF47;
  localparam logic [15:0] ADR_EDGE_UP = 16'hFFED;
  localparam logic [15:0] ADR_EDGE_LO = 16'hFFEC;
  localparam logic [15:0] ADR_PSW     = 16'hFF1E;

  localparam logic [7:0] RST_SCS  = 8'h00;
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [7:0] RST_PSW  = 8'h02;
  localparam logic [7:0] RD_NONE  = 8'h00;

  // Status word bit positions
  localparam int unsigned PSW_IE  = 7;
  localparam int unsigned PSW_ISP = 1;

  // Edge field positions: lower register holds pins 0..2, upper pins 3..5
  localparam int unsigned EDGE_LO_POS = 2;
  localparam int unsigned EDGE_LO_N   = 3;

  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BAD  = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Sampling clock select codes and divider exponents of fx
  localparam logic [1:0] SCS_CPU  = 2'h0;
  localparam logic [1:0] SCS_DIVA = 2'h1;
  localparam logic [1:0] SCS_DIVB = 2'h2;
  localparam logic [3:0] EXP_M1_A = 4'h7;
  localparam logic [3:0] EXP_M1_B = 4'h5;
  localparam logic [3:0] EXP_M1_C = 4'h6;
  localparam logic [3:0] EXP_M0_A = 4'h8;
  localparam logic [3:0] EXP_M0_B = 4'h6;
  localparam logic [3:0] EXP_M0_C = 4'h7;

  typedef enum logic [0:0] {
    ST_IDLE    = 1'b0,
    ST_LOWWAIT = 1'b1
  } eia_state_t;
endpackage

// ===== sim/eia_cpu_model.sv
/*
  Behavioural CPU sequencer: issues one instruction at a time and records
  the acknowledge and status push that follow it.
  Assumes the block answers within two cycles of the instruction end.
*/
`timescale 1ns/1ns
module eia_cpu_model (
  input  wire logic       clk,
  input  wire logic       ack,
  input  wire logic       ack_nmi,
  input  wire logic [3:0] ack_src,
  input  wire logic       psw_push,
  input  wire logic [7:0] push_data,
  output logic            instr_done,
  output logic      [7:0] kind,
  output logic      [7:0] pop_data
);
  logic [1:0] lat;
  logic       was_nmi;
  logic [3:0] src;
  logic       pushed;
  logic [7:0] pushed_val;

  initial
  begin
    instr_done = 1'b0;
    kind       = 8'h00;
    pop_data   = 8'h00;
  end

  // Kind is one-hot: EI, DI, SOFTWARE_BREAK_INSTR, INTERRUPT_RETURN_INSTR, BREAK_RETURN_INSTR, PUSH, POP, other hold
  // Three observed cycles keep a three-cycle gap between instructions
  task automatic step(input logic [7:0] k, input logic [7:0] pd);
    begin
      @(negedge clk);
      instr_done = 1'b1;
      kind       = k;
      pop_data   = pd;
      lat        = 2'h0;
      pushed     = 1'b0;
      for (int i = 1; i <= 3; i++)
      begin
        @(negedge clk);
        instr_done = 1'b0;
        kind       = 8'h00;
        // Stack byte no longer valid: show a different value
        pop_data   = ~pd;
        if (ack === 1'b1 && lat === 2'h0)
        begin
          lat     = 2'(i);
          was_nmi = ack_nmi;
          src     = ack_src;
        end
        if (psw_push === 1'b1)
        begin
          pushed     = 1'b1;
          pushed_val = push_data;
        end
      end
    end
  endtask
endmodule

// ===== sim/eia_top_test.sv
/*
  Self-checking bench for the edge select, pin 0 filter, status word and
  acknowledge logic. Assumes the sequencer model in eia_cpu_model.
*/
`timescale 1ns/1ns
`define CHK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("BAD %s expected %h seen %h", what, exp, got); \
    end \
  end
module eia_top_test;
  localparam logic [7:0] K_NO = 8'h00;
  localparam logic [7:0] K_EI = 8'h01;
  localparam logic [7:0] K_DI = 8'h02;
  localparam logic [7:0] K_BK = 8'h04;
  localparam logic [7:0] K_RI = 8'h08;
  localparam logic [7:0] K_RB = 8'h10;
  localparam logic [7:0] K_PU = 8'h20;
  localparam logic [7:0] K_PO = 8'h40;
  logic        clk   = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  pins  = 6'h00;
  logic [9:0]  other = 10'h000;
  logic        nmi   = 1'b0;
  logic [15:0] mask  = 16'hFFFF;
  logic [15:0] prio  = 16'hFFFF;
  logic        halt  = 1'b0;
  logic        osc   = 1'b1;
  logic [15:0] addr  = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        we    = 1'b0;
  logic        re    = 1'b0;
  logic        done;
  logic [7:0]  kind;
  logic [7:0]  pop;
  logic [7:0]  rdata;
  logic [7:0]  processor_status_word;
  logic [15:0] flags;
  logic        nmi_srv;
  logic        nmi_pnd;
  logic        ack;
  logic        ack_nmi;
  logic [3:0]  src;
  logic        push;
  logic [7:0]  push_d;
  logic [7:0]  keep;
  int          n_fail     = 0;
  int          num_checks = 0;
  int          cycles     = 0;

  always #4 clk = ~clk;

  eia_top eia_top_inst (.CLK(clk), .RESET(reset), .CE(1'b1), .EXT_IRQ_PIN(pins),
    .OTHER_REQ(other), .NMI_REQ(nmi), .MASK_FLAGS(mask), .PRIO_FLAGS(prio),
    .OSC_MODE_BIT(osc), .FXX_HALF(1'b0), .CPU_DIV_N(3'h0), .HALT_MODE(halt),
    .INSTR_DONE(done), .HOLD_INSTR(kind[7]), .EI_INSTR(kind[0]), .DI_INSTR(kind[1]),
    .BRK_INSTR(kind[2]), .INTERRUPT_RETURN_INSTR_INSTR(kind[3]), .BREAK_RETURN_INSTR_INSTR(kind[4]),
    .PUSH_PSW_INSTR(kind[5]), .POP_PSW_INSTR(kind[6]), .POP_DATA(pop),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata),
    .PROCESSOR_STATUS_WORD(processor_status_word), .REQ_FLAGS(flags), .NMI_PENDING(nmi_pnd), .NMI_IN_SERVICE(nmi_srv),
    .ACK(ack), .ACK_NMI(ack_nmi), .ACK_SRC(src), .PSW_PUSH(push),
    .PSW_PUSH_DATA(push_d));

  eia_cpu_model eia_cpu_model_inst (.clk(clk), .ack(ack), .ack_nmi(ack_nmi),
    .ack_src(src), .psw_push(push), .push_data(push_d), .instr_done(done),
    .kind(kind), .pop_data(pop));

  task automatic conclude();
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // Well past the roughly 540 cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_fail++;
      conclude();
    end
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    begin
      @(negedge clk);
      addr  = a;
      wdata = d;
      we    = 1'b1;
      @(negedge clk);
      we    = 1'b0;
      wdata = ~d;
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    begin
      @(negedge clk);
      addr = a;
      re   = 1'b1;
      @(negedge clk);
      re   = 1'b0;
      `CHK("read", exp, rdata)
    end
  endtask

  task automatic pulse(input logic [9:0] o, input logic n);
    begin
      @(negedge clk);
      other = o;
      nmi   = n;
      @(negedge clk);
      other = 10'h000;
      nmi   = 1'b0;
    end
  endtask

  task automatic set_pins(input logic [5:0] p, input int hold);
    begin
      pins = p;
      repeat (hold) @(negedge clk);
    end
  endtask

  // Negative latency skips the acknowledge check
  task automatic run(input logic [7:0] k, input logic [7:0] pd, input int l,
                     input logic nm, input logic [3:0] s);
    begin
      eia_cpu_model_inst.step(k, pd);
      if (l >= 0)
        `CHK("ack_lat", 2'(l), eia_cpu_model_inst.lat)
      if (l > 0)
      begin
        `CHK("ack_nmi", nm, eia_cpu_model_inst.was_nmi)
        `CHK("pushed", 1'b1, eia_cpu_model_inst.pushed)
        if (!nm)
          `CHK("ack_src", s, eia_cpu_model_inst.src)
      end
    end
  endtask

  initial
  begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    `CHK("psw", 8'h02, processor_status_word)
    rd(eia_pkg::ADR_SCS, 8'h00);
    rd(eia_pkg::ADR_EDGE_UP, 8'h00);
    rd(eia_pkg::ADR_EDGE_LO, 8'h00);
    rd(eia_pkg::ADR_PSW, 8'h02);
    rd(16'hFF00, 8'h00);
    wr(eia_pkg::ADR_SCS, 8'hFF);
    rd(eia_pkg::ADR_SCS, 8'h03);
    wr(eia_pkg::ADR_SCS, 8'h00);
    $display("register test done");
    set_pins(6'h3E, 4);
    `CHK("flags", 5'h00, flags[5:1])
    wr(eia_pkg::ADR_EDGE_UP, 8'hFF);
    rd(eia_pkg::ADR_EDGE_UP, 8'h3F);
    wr(eia_pkg::ADR_EDGE_UP, 8'h0F);
    wr(eia_pkg::ADR_EDGE_LO, 8'h44);
    rd(eia_pkg::ADR_EDGE_LO, 8'h44);
    set_pins(6'h00, 4);
    `CHK("flags", 5'h1D, flags[5:1])
    set_pins(6'h3E, 4);
    `CHK("flags", 5'h1F, flags[5:1])
    set_pins(6'h00, 2);
    halt = 1'b1;
    set_pins(6'h01, 8);
    set_pins(6'h00, 4);
    `CHK("pin0", 1'b0, flags[0])
    halt = 1'b0;
    // Divided sampling: a pulse shorter than one period is seen once at most
    wr(eia_pkg::ADR_SCS, 8'h02);
    set_pins(6'h01, 30);
    set_pins(6'h00, 40);
    `CHK("pin0_div32", 1'b0, flags[0])
    osc = 1'b0;
    wr(eia_pkg::ADR_SCS, 8'h01);
    set_pins(6'h01, 250);
    wr(eia_pkg::ADR_SCS, 8'h00);
    set_pins(6'h00, 4);
    `CHK("pin0_div256", 1'b0, flags[0])
    osc = 1'b1;
    set_pins(6'h01, 1);
    set_pins(6'h00, 4);
    `CHK("pin0", 1'b0, flags[0])
    set_pins(6'h01, 6);
    `CHK("pin0", 1'b1, flags[0])
    wr(eia_pkg::ADR_EDGE_LO, 8'h08);
    set_pins(6'h00, 6);
    rd(eia_pkg::ADR_EDGE_LO, 8'h08);
    $display("edge test done");
    mask = 16'hFC3F;
    prio = 16'hFC7F;
    run(K_EI, 8'h00, 0, 1'b0, 4'h0);
    `CHK("ie", 1'b1, processor_status_word[7])
    run(K_BK, 8'h00, -1, 1'b0, 4'h0);
    `CHK("brk_push", 1'b1, eia_cpu_model_inst.pushed)
    `CHK("brk_ie", 1'b0, processor_status_word[7])
    pulse(10'h000, 1'b1);
    run(K_NO, 8'h00, 1, 1'b1, 4'h0);
    `CHK("nmi_psw", 8'h00, processor_status_word & 8'h82)
    `CHK("nmi_srv", 1'b1, nmi_srv)
    pulse(10'h008, 1'b1);
    pulse(10'h000, 1'b1);
    `CHK("nmi_pend", 1'b1, nmi_pnd)
    run(K_EI, 8'h00, 0, 1'b0, 4'h0);
    run(K_NO, 8'h00, 0, 1'b0, 4'h0);
    run(K_RI, 8'h82, 0, 1'b0, 4'h0);
    run(K_NO, 8'h00, 1, 1'b1, 4'h0);
    `CHK("nmi_pend", 1'b0, nmi_pnd)
    run(K_NO, 8'h00, 0, 1'b0, 4'h0);
    run(K_RI, 8'h82, 0, 1'b0, 4'h0);
    run(K_NO, 8'h00, 1, 1'b0, 4'h9);
    `CHK("isp", 2'h0, {processor_status_word[7], processor_status_word[1]})
    `CHK("flag9", 1'b0, flags[9])
    pulse(10'h001, 1'b0);
    run(K_EI, 8'h00, 0, 1'b0, 4'h0);
    run(K_NO, 8'h00, 0, 1'b0, 4'h0);
    pulse(10'h006, 1'b0);
    run(K_NO, 8'h00, 1, 1'b0, 4'h7);
    run(K_EI, 8'h00, 0, 1'b0, 4'h0);
    run(K_NO, 8'h00, 1, 1'b0, 4'h8);
    run(K_RI, 8'h82, 0, 1'b0, 4'h0);
    run(K_NO, 8'h00, 2, 1'b0, 4'h6);
    `CHK("isp", 1'b1, processor_status_word[1])
    pulse(10'h009, 1'b0);
    run(K_EI, 8'h00, 0, 1'b0, 4'h0);
    run(K_NO, 8'h00, 1, 1'b0, 4'h9);
    mask[6] = 1'b1;
    run(K_RI, 8'h82, 0, 1'b0, 4'h0);
    run(K_NO, 8'h00, 0, 1'b0, 4'h0);
    mask[6] = 1'b0;
    run(K_NO, 8'h00, 2, 1'b0, 4'h6);
    keep = processor_status_word;
    run(K_PU, 8'h00, 0, 1'b0, 4'h0);
    `CHK("push", keep, eia_cpu_model_inst.pushed_val)
    run(K_PO, 8'h03, 0, 1'b0, 4'h0);
    `CHK("pop", 8'h03, processor_status_word)
    run(K_RB, 8'h82, 0, 1'b0, 4'h0);
    `CHK("break_return_instr", 8'h82, processor_status_word)
    run(K_DI, 8'h00, 0, 1'b0, 4'h0);
    `CHK("di", 8'h02, processor_status_word)
    wr(eia_pkg::ADR_PSW, 8'h01);
    rd(eia_pkg::ADR_PSW, 8'h01);
    $display("acknowledge test done");
    conclude();
  end
endmodule
